// ---- plf_pkg.sv ----
package plf_pkg;
   // line geometry and limits
   localparam int LINE_BYTES = 16;
   localparam int WIN_BYTES = 24;
   localparam logic [3:0] MAX_LEN = 4'hF;
   // pre-decode costs in core cycles
   localparam int FAST_CYC = 1;
   localparam int SLOW_CYC = 6;
   localparam int DBL_PEN = 11;
   // second line of a double stall makes the total penalty DBL_PEN
   localparam int SECOND_CYC = DBL_PEN - (SLOW_CYC - FAST_CYC) + FAST_CYC;
   // byte codes
   localparam logic [7:0] PFX_OPSZ = 8'h66;
   localparam logic [7:0] PFX_ADSZ = 8'h67;
   localparam logic [7:0] OP_ESC = 8'h0F;
   localparam logic [7:0] OP_GRP3 = 8'hF7;
   localparam logic [7:0] OP_GRP3B = 8'hF6;
   localparam logic [3:0] REX_HI = 4'h4;
   localparam logic [3:0] JCC_HI = 4'h7;
   localparam logic [3:0] JCC32_HI = 4'h8;
   localparam logic [2:0] REG_CMP = 3'h7;
   localparam logic [2:0] REG_TEST = 3'h0;
   localparam logic [1:0] MOD_REG = 2'h3;
   localparam logic [1:0] MOD_D8 = 2'h1;
   localparam logic [1:0] MOD_D32 = 2'h2;
   localparam logic [2:0] RM_SIB = 3'h4;
   localparam logic [2:0] RM_ABS = 3'h5;
   // special offsets in a fetch line
   localparam logic [4:0] DBL_D8_OFS = 5'h0D;
   localparam logic [4:0] FALSE_OFS = 5'h0E;
   localparam logic [4:0] LAST_OFS = 5'h0F;
   // condition codes testing only carry or zero
   localparam logic [15:0] CMP_CC_MASK = 16'h00FC;

   typedef struct packed {
      logic restart;
      logic [3:0] entry;
      logic [8*LINE_BYTES-1:0] bytes;
   } plf_line_t;

   typedef struct packed {
      logic [3:0] cycles;
      logic [15:0] starts;
      logic [15:0] length_changing_prefix;
      logic [15:0] fuse;
   } plf_res_t;

   typedef struct packed {
      logic [4:0] len;
      logic length_changing_prefix, dbl, cmp, test, zcmp, memimm, jcc;
      logic [3:0] cc;
   } plf_insn_t;

   typedef enum logic [1:0] {
      PLF_IDLE = 2'b00,
      PLF_RUN = 2'b01
   } plf_state_t;
endpackage

// ---- plf_predecode.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// result queue between pre-decode and the decoders
module plf_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr, rd;
   logic [AW:0] cnt;
   logic push, pop;

   assign in_ready_o = (cnt != D[AW:0]);
   assign out_valid_o = (cnt != '0);
   assign out_data_o = mem[rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage, no reset needed for data
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr] <= in_data_i;
      end
   end

   // pointers wrap at depth, so depth need not be a power of two
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wr <= '0;
         rd <= '0;
         cnt <= '0;
      end else begin
         if (push) begin
            wr <= (wr == AW'(D - 1)) ? '0 : wr + 1'b1;
         end
         if (pop) begin
            rd <= (rd == AW'(D - 1)) ? '0 : rd + 1'b1;
         end
         cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   property p_no_overfill;
      @(posedge clk_i) disable iff (!rstn_i)
      (cnt == D[AW:0]) && !pop |-> !in_ready_o ##1 cnt == D[AW:0];
   endproperty
   a_no_overfill: assert property (p_no_overfill) // see RULE_22
      else $error("queue accepted while full");
endmodule

////////////////////////////////////////////////////////////////////////////
// Function
// RULE_01: lengths from one up to fifteen bytes are estimated.
// RULE_02: a line without length-changing prefix takes one cycle.
// RULE_03: a line with a length-changing prefix takes six cycles.
// RULE_04: operand-size 66 and address-size 67 prefixes count as length-changing.
// RULE_05: fixed sixteen-bit immediates without size prefix never stall.
// RULE_06: the long-mode register extension prefix never causes the stall.
// RULE_07: a stalling instruction crossing the line may stall both lines.
// RULE_08: line boundary between operand-form and scaled-index byte gives double stall.
// RULE_09: byte-displacement form starting at offset 13 gives double stall.
// RULE_10: a double stall costs eleven cycles of penalty in total.
// RULE_11: other memory forms stall once wherever they start.
// RULE_12: prefixed F7 opcode at offset 14 stalls falsely at full cost.
// RULE_13: false stall covers the whole F7 group, length unknown there.
// RULE_14: compare memory-immediate with signed jump is not fused.
// RULE_15: compare register-immediate with unsigned jump is fused.
// RULE_16: test fuses with every conditional jump, signed ones too.
// RULE_17: compare with zero behaves as test of value with itself; the code still pairs it as a compare.
// RULE_18: only compare or test heads a pair, conditional branch follows.
// RULE_19: compare fuses only with jumps reading carry_flag or zero_flag.
// RULE_20: no fusion at all in 64-bit mode.
// RULE_21: at most one fused pair per cycle.
// RULE_22: each line reports its cycles and a fusion flag per pair.
module plf_predecode #(
   parameter int QDEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // core mode
   input wire logic mode64_i,
   // fetch lines from fetch unit
   input wire logic line_valid_i,
   input wire plf_pkg::plf_line_t line_i,
   output logic line_ready_o,
   // results to decoders
   output logic res_valid_o,
   output plf_pkg::plf_res_t res_o,
   input wire logic res_ready_i
);
   import plf_pkg::*;

   plf_state_t state;
   logic [3:0] cnt, carry;
   logic dbl_pend, acc, push, q_ready;
   plf_res_t held;
   logic [15:0] an_starts, an_lcp, an_fuse;
   logic an_slow, an_dbl;
   logic [3:0] an_carry, an_cost;
   logic [8*WIN_BYTES-1:0] win;

   ////////////////////////////////////////////////////////////////////////
   // byte fetch from the analysis window
   function automatic logic [7:0] bt(input logic [8*WIN_BYTES-1:0] w,
                                     input logic [4:0] k);
      return w[{k, 3'b000} +: 8];
   endfunction

   // fast length estimate of one instruction, plus stall and pair class
   function automatic plf_insn_t est(input logic [8*WIN_BYTES-1:0] w,
                                     input logic [4:0] p,
                                     input logic m64);
      plf_insn_t r;
      logic [4:0] i, ln;
      logic [7:0] o, mr, sb;
      logic p66, p67, go, hm, iz, i8, i16, mo, scaled_index_byte, fls;
      logic [2:0] dsp;
      r = '0;
      i = p;
      p66 = 1'b0;
      p67 = 1'b0;
      go = 1'b1;
      for (int k = 0; k < 4; k++) begin
         o = bt(w, i);
         if (go && o == PFX_OPSZ) begin
            p66 = 1'b1;
            i = i + 5'd1;
         end else if (go && o == PFX_ADSZ) begin
            p67 = 1'b1;
            i = i + 5'd1;
         end else if (go && m64 && o[7:4] == REX_HI) begin
            i = i + 5'd1; // only skipped, never a stall, see RULE_06
         end else begin
            go = 1'b0;
         end
      end
      o = bt(w, i);
      if (o == OP_ESC) begin
         i = i + 5'd1;
         o = bt(w, i);
         r.jcc = (o[7:4] == JCC32_HI);
         hm = !r.jcc;
         iz = r.jcc;
         i8 = 1'b0;
         i16 = 1'b0;
         mo = 1'b0;
      end else begin
         hm = (o < 8'h40 && !o[2]) || o inside {8'h62, 8'h63, 8'h69,
              8'h6B, [8'h80:8'h8F], 8'hC0, 8'hC1, 8'hC6, 8'hC7,
              [8'hD0:8'hD3], OP_GRP3B, OP_GRP3, 8'hFE, 8'hFF};
         iz = (o < 8'h40 && o[2:0] == 3'h5) || o inside {8'h68, 8'h69,
              8'h81, 8'hC7, 8'hA9, [8'hB8:8'hBF], 8'hE8, 8'hE9};
         i8 = (o < 8'h40 && o[2:0] == 3'h4) || o inside {8'h6A, 8'h6B,
              [8'h70:8'h7F], 8'h80, 8'h83, 8'hA8, [8'hB0:8'hB7], 8'hC0,
              8'hC1, 8'hC6, 8'hCD, 8'hEB, [8'hE0:8'hE3]};
         i16 = o inside {8'hC2, 8'hCA}; // fixed width, see RULE_05
         mo = o inside {[8'hA0:8'hA3]};
         r.jcc = (o[7:4] == JCC_HI);
      end
      r.cc = o[3:0];
      mr = hm ? bt(w, i + 5'd1) : '0;
      sb = bt(w, i + 5'd2);
      if (o == OP_GRP3 && mr[5:3] == REG_TEST) iz = 1'b1;
      if (o == OP_GRP3B && mr[5:3] == REG_TEST) i8 = 1'b1;
      scaled_index_byte = hm && mr[7:6] != MOD_REG && mr[2:0] == RM_SIB;
      dsp = 3'd0;
      if (hm && mr[7:6] == MOD_D8) dsp = 3'd1;
      if (hm && mr[7:6] == MOD_D32) dsp = 3'd4;
      if (hm && mr[7:6] == 2'h0 && mr[2:0] == RM_ABS) dsp = 3'd4;
      if (scaled_index_byte && mr[7:6] == 2'h0 && sb[2:0] == RM_ABS) dsp = 3'd4;
      if (mo) dsp = 3'd4;
      ln = i - p + 5'd1 + 5'(hm) + 5'(scaled_index_byte) + 5'(dsp) + 5'(i8)
         + (iz ? (p66 ? 5'd2 : 5'd4) : 5'd0) + (i16 ? 5'd2 : 5'd0);
      r.len = (ln > 5'(MAX_LEN)) ? 5'(MAX_LEN) : ln; // see RULE_01
      // operand form byte still in the next line: length unresolved
      fls = p66 && p == FALSE_OFS && o == OP_GRP3; // see RULE_12, RULE_13
      r.length_changing_prefix = (p66 && iz) || (p67 && hm && mr[7:6] != MOD_REG)
            || fls; // see RULE_04
      r.dbl = r.length_changing_prefix && ((scaled_index_byte && i + 5'd1 == LAST_OFS) // see RULE_08
            || (p == DBL_D8_OFS && hm && mr[7:6] == MOD_D8)); // see RULE_09
      r.cmp = (o >= 8'h38 && o <= 8'h3D)
            || (o inside {8'h80, 8'h81, 8'h83} && mr[5:3] == REG_CMP);
      r.test = o inside {8'h84, 8'h85, 8'hA8, 8'hA9}
             || (o inside {OP_GRP3B, OP_GRP3} && mr[5:3] == REG_TEST);
      r.memimm = hm && mr[7:6] != MOD_REG && (i8 || iz); // see RULE_14
      // zero compare leaves self-test flags, pairs as a compare, see RULE_17
      r.zcmp = r.cmp && o inside {8'h80, 8'h83} && mr[7:6] == MOD_REG
             && sb == 8'h00;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // walk the line from its entry offset, one estimate per instruction
   always_comb begin
      logic [4:0] pos, hp;
      plf_insn_t c, h;
      logic hv, done;
      pos = {1'b0, (line_i.restart ? line_i.entry : carry)};
      win = {64'h0, line_i.bytes};
      an_starts = '0;
      an_lcp = '0;
      an_fuse = '0;
      an_dbl = 1'b0;
      h = '0;
      c = '0;
      hp = '0;
      hv = 1'b0;
      done = 1'b0;
      for (int k = 0; k < LINE_BYTES; k++) begin
         if (!pos[4]) begin
            c = est(win, pos, mode64_i);
            an_starts[pos[3:0]] = 1'b1;
            an_lcp[pos[3:0]] = c.length_changing_prefix;
            an_dbl = an_dbl || c.dbl; // see RULE_07
            // head must directly precede a branch, see RULE_18
            if (hv && c.jcc && !mode64_i && !done && !h.memimm
                && (h.test // see RULE_16
                    || (h.cmp && CMP_CC_MASK[c.cc]))) begin // see RULE_19
               an_fuse[hp[3:0]] = 1'b1; // see RULE_15, RULE_20
               done = 1'b1; // see RULE_21
            end
            hv = c.cmp || c.test;
            h = c;
            hp = pos;
            pos = pos + c.len;
         end
      end
      an_carry = pos[3:0];
   end

   // a line with one stalling instruction, whatever its form, pays once
   assign an_slow = (an_lcp != '0); // see RULE_11
   always_comb begin
      an_cost = an_slow ? 4'(SLOW_CYC) : 4'(FAST_CYC); // see RULE_02, RULE_03
      if (dbl_pend && !line_i.restart && an_cost < 4'(SECOND_CYC)) begin
         an_cost = 4'(SECOND_CYC); // see RULE_10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // handshakes: a finishing line hands over in the same cycle
   assign push = (state == PLF_RUN) && (cnt == '0);
   assign line_ready_o = (state == PLF_IDLE) || (push && q_ready);
   assign acc = line_valid_i && line_ready_o;

   // control state
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state <= PLF_IDLE;
      end else if (acc) begin
         state <= PLF_RUN;
      end else if (push && q_ready) begin
         state <= PLF_IDLE;
      end
   end

   // cycle budget of the line in flight
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cnt <= '0;
      end else if (acc) begin
         cnt <= an_cost - 4'd1;
      end else if (state == PLF_RUN && cnt != '0) begin
         cnt <= cnt - 4'd1;
      end
   end

   // carry into next line: entry offset and pending second stall
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         carry <= '0;
         dbl_pend <= 1'b0;
      end else if (acc) begin
         carry <= an_carry;
         dbl_pend <= an_dbl; // see RULE_07
      end
   end

   // latched result of the accepted line
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         held <= '0;
      end else if (acc) begin
         held <= '{cycles: an_cost, starts: an_starts, length_changing_prefix: an_lcp,
                   fuse: an_fuse}; // see RULE_22
      end
   end

   // queue absorbs decoder stalls; a full queue holds the line in flight
   plf_fifo #(.W($bits(plf_res_t)), .D(QDEPTH)) u_q (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(push),
      .in_data_i(held),
      .in_ready_o(q_ready),
      .out_valid_o(res_valid_o),
      .out_data_o(res_o),
      .out_ready_i(res_ready_i)
   );

   ////////////////////////////////////////////////////////////////////////
   property p_fast;
      @(posedge clk_i) disable iff (!rstn_i)
      (acc && !an_slow && !(dbl_pend && !line_i.restart))
         |=> push;
   endproperty
   a_fast: assert property (p_fast) // see RULE_02
      else $error("clean line not done in one cycle");
   property p_slow;
      @(posedge clk_i) disable iff (!rstn_i)
      (acc && an_slow && !(dbl_pend && !line_i.restart))
         |=> (!push)[*5] ##1 push;
   endproperty
   a_slow: assert property (p_slow) // see RULE_03
      else $error("prefixed line not held six cycles");
   property p_second;
      @(posedge clk_i) disable iff (!rstn_i)
      (acc && dbl_pend && !line_i.restart)
         |-> an_cost == 4'(SECOND_CYC)
             && (SLOW_CYC - FAST_CYC) + (SECOND_CYC - FAST_CYC) == DBL_PEN
             ##1 (!push)[*6] ##1 push;
   endproperty
   a_second: assert property (p_second) // see RULE_10
      else $error("double stall penalty wrong");

   property p_dbl_carry;
      @(posedge clk_i) disable iff (!rstn_i)
      (acc && an_dbl) |=> dbl_pend && state == PLF_RUN;
   endproperty
   a_dbl_carry: assert property (p_dbl_carry) // see RULE_07
      else $error("double stall not carried to next line");

   property p_one_fuse;
      @(posedge clk_i) disable iff (!rstn_i)
      push |-> $onehot0(held.fuse);
   endproperty
   a_one_fuse: assert property (p_one_fuse) // see RULE_21
      else $error("more than one fused pair in a line");

   property p_no_fuse64;
      @(posedge clk_i) disable iff (!rstn_i)
      (acc && mode64_i) |=> held.fuse == '0;
   endproperty
   a_no_fuse64: assert property (p_no_fuse64) // see RULE_20
      else $error("fusion in 64-bit mode");

   property p_report;
      @(posedge clk_i) disable iff (!rstn_i)
      acc |=> held.cycles == $past(an_cost) && held.starts != '0
              || $past(an_starts) == '0;
   endproperty
   a_report: assert property (p_report) // see RULE_22
      else $error("line report does not match analysis");

   property p_lcp_slow;
      @(posedge clk_i) disable iff (!rstn_i)
      (acc && an_lcp != '0) |-> an_cost >= 4'(SLOW_CYC);
   endproperty
   a_lcp_slow: assert property (p_lcp_slow) // see RULE_04
      else $error("length-changing prefix not charged");
endmodule

// ---- plf_partner.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// fetch unit and decoder stand-in for the pre-decoder
module plf_partner (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // fetch side
   output logic line_valid_o,
   output plf_pkg::plf_line_t line_o,
   input wire logic line_ready_i,
   // decoder side
   input wire logic res_valid_i,
   input wire plf_pkg::plf_res_t res_i,
   output logic res_ready_o
);
   import plf_pkg::*;
   plf_line_t tx_q[$];
   plf_res_t rx_q[$];
   logic stall = 1'b0;
   // quiet outputs before the first edge
   initial begin
      line_valid_o = 1'b0;
      res_ready_o = 1'b0;
      line_o = '0;
   end
   // a line is held until taken; a released line's bytes invert again on every idle cycle,
   // so a stale copy shows its true bytes on every second cycle
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         line_valid_o <= 1'b0;
         res_ready_o <= 1'b0;
      end else begin
         if (!line_valid_o || line_ready_i) begin
            if (tx_q.size() > 0) begin
               line_valid_o <= 1'b1;
               line_o <= tx_q.pop_front();
            end else begin
               line_valid_o <= 1'b0;
               line_o <= ~line_o;
            end
         end
         // decoders stall on request, else take every word
         if (res_valid_i && res_ready_o) begin
            rx_q.push_back(res_i);
         end
         res_ready_o <= !stall;
      end
   end
endmodule

// ---- plf_predecode_test.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// self-checking bench for the pre-decoder
module plf_predecode_test;
   import plf_pkg::*;
   logic clk_i;
   logic rstn_i = 1'b0;
   logic mode64_i = 1'b0;
   logic line_valid, line_ready, res_valid, res_ready;
   plf_line_t line;
   plf_res_t res;
   plf_line_t l1, l2;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;

   plf_partner u_part (.clk_i(clk_i), .rstn_i(rstn_i),
      .line_valid_o(line_valid), .line_o(line), .line_ready_i(line_ready),
      .res_valid_i(res_valid), .res_i(res), .res_ready_o(res_ready));
   plf_predecode #(.QDEPTH(8)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
      .mode64_i(mode64_i), .line_valid_i(line_valid), .line_i(line),
      .line_ready_o(line_ready), .res_valid_o(res_valid), .res_o(res),
      .res_ready_i(res_ready));

   // 100 MHz core clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // hang guard, far above the expected run length
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // two lines of filler, bytes placed from ofs, spilling into l2
   task automatic build(input logic [7:0] q[$], input int ofs);
      l1 = '0;
      l1.restart = 1'b1;
      l1.bytes = {16{8'h90}};
      l2 = l1;
      l2.restart = 1'b0;
      foreach (q[i]) begin
         if (ofs + i < 16) l1.bytes[8*(ofs+i) +: 8] = q[i];
         else l2.bytes[8*(ofs+i-16) +: 8] = q[i];
      end
   endtask

   task automatic get(output plf_res_t r);
      int n;
      n = 0;
      while (u_part.rx_q.size() == 0 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      r = '0;
      if (n >= 200) check(16'h0bad, 16'h0000);
      else r = u_part.rx_q.pop_front();
   endtask

   // single line through, with the chosen mode held around the take
   task automatic one_line(input logic [7:0] q[$], input logic m64,
                           output plf_res_t r);
      build(q, 0);
      mode64_i <= m64;
      @(posedge clk_i);
      u_part.tx_q.push_back(l1);
      get(r);
   endtask

   task automatic t_fast();
      plf_res_t r;
      one_line({8'h90}, 1'b0, r);
      check(r.cycles, 16'h1);
      check(r.starts, 16'hffff);
      check(r.length_changing_prefix, 16'h0);
      // eleven-byte form with scaled index, disp32 and imm32
      one_line({8'h81, 8'h84, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00,
                8'h01, 8'h00, 8'h00, 8'h00}, 1'b0, r);
      check(r.starts, 16'hf801);
   endtask

   task automatic t_lcp();
      plf_res_t r;
      one_line({8'h66, 8'hb8, 8'h34, 8'h12}, 1'b0, r);
      check(r.cycles, 16'h6);
      check(r.length_changing_prefix, 16'h0001);
      one_line({8'h67, 8'h8b, 8'h00}, 1'b0, r);
      check(r.cycles, 16'h6);
      one_line({8'hc2, 8'h34, 8'h12}, 1'b0, r);
      check(r.cycles, 16'h1);
      one_line({8'h48, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12}, 1'b1, r);
      check(r.cycles, 16'h1);
   endtask

   // stalling insn across the boundary; exp2 is the second line's cost
   task automatic pair(input logic [7:0] q[$], input int ofs,
                       input logic [3:0] exp2);
      plf_res_t r1, r2;
      build(q, ofs);
      u_part.tx_q.push_back(l1);
      u_part.tx_q.push_back(l2);
      get(r1);
      get(r2);
      check(r1.cycles, 16'h6);
      check(r2.cycles, {12'h0, exp2});
   endtask

   task automatic t_cross();
      // eleven cycles of penalty, five of them in the first line
      logic [3:0] dbl;
      dbl = 4'(1 + 11 - (6 - 1));
      pair({8'h66, 8'h81, 8'h40, 8'h12, 8'h34, 8'h12}, 13, dbl);
      pair({8'h66, 8'h66, 8'h81, 8'h04, 8'h30, 8'h34, 8'h12}, 12, dbl);
      pair({8'h66, 8'h81, 8'hc0, 8'h34, 8'h12}, 13, 4'h1);
      pair({8'h66, 8'h81, 8'h00, 8'h34, 8'h12}, 13, 4'h1);
      pair({8'h66, 8'h81, 8'h80, 8'h78, 8'h56, 8'h34, 8'h12, 8'h34,
            8'h12}, 13, 4'h1);
      pair({8'h66, 8'h81, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12, 8'h34,
            8'h12}, 13, 4'h1);
   endtask

   // group members two to seven, each with its form byte in the next line
   task automatic t_false();
      plf_res_t r1, r2;
      for (int g = 2; g < 8; g++) begin
         build({8'h66, 8'hf7, 8'hc0 | 8'(g << 3)}, 14);
         u_part.tx_q.push_back(l1);
         u_part.tx_q.push_back(l2);
         get(r1);
         get(r2);
         check(r1.cycles, 16'h6);
         check(r1.length_changing_prefix, 16'h4000);
      end
   endtask

   task automatic fz(input logic [7:0] q[$], input logic m64,
                     input logic exp);
      plf_res_t r;
      one_line(q, m64, r);
      check(r.fuse, {15'h0, exp});
   endtask

   task automatic t_fuse();
      fz({8'h83, 8'hf8, 8'h4d, 8'h73, 8'h00}, 1'b0, 1'b1);
      fz({8'h83, 8'hf8, 8'h4d, 8'h73, 8'h00}, 1'b1, 1'b0);
      fz({8'h83, 8'h38, 8'h4d, 8'h7d, 8'h00}, 1'b0, 1'b0);
      fz({8'h83, 8'h38, 8'h4d, 8'h73, 8'h00}, 1'b0, 1'b0);
      fz({8'h85, 8'hc9, 8'h7e, 8'h00}, 1'b0, 1'b1);
      fz({8'h85, 8'hc9, 8'h7c, 8'h00}, 1'b0, 1'b1);
      fz({8'h83, 8'hf8, 8'h00, 8'h7c, 8'h00}, 1'b0, 1'b0);
      fz({8'h83, 8'hf8, 8'h00, 8'h74, 8'h00}, 1'b0, 1'b1);
      fz({8'h01, 8'hc8, 8'h74, 8'h00}, 1'b0, 1'b0);
      fz({8'h85, 8'hc0, 8'h90, 8'h74, 8'h00}, 1'b0, 1'b0);
      fz({8'h85, 8'hc0, 8'h0f, 8'h84, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0,
         1'b1);
      // two fusible pairs: only the first may fuse
      fz({8'h85, 8'hc0, 8'h74, 8'h00, 8'h85, 8'hc0, 8'h74, 8'h00}, 1'b0,
         1'b1);
      // compare fuses only with carry or zero conditions, test with all
      for (int cc = 0; cc < 16; cc++) begin
         fz({8'h85, 8'hc9, 8'h70 | 8'(cc), 8'h00}, 1'b0, 1'b1);
         fz({8'h39, 8'hc8, 8'h70 | 8'(cc), 8'h00}, 1'b0,
            cc >= 2 && cc <= 7);
      end
   endtask

   // fill the queue with the decoders stalled, then drain it empty
   task automatic t_fill();
      plf_res_t r;
      build({8'h90}, 0);
      u_part.stall <= 1'b1;
      repeat (10) u_part.tx_q.push_back(l1);
      repeat (30) @(posedge clk_i);
      #1;
      check(line_ready, 16'h0);
      check(res_valid, 16'h1);
      @(posedge clk_i);
      u_part.stall <= 1'b0;
      repeat (10) begin
         get(r);
         check(r.cycles, 16'h1);
      end
      repeat (3) @(posedge clk_i);
      #1;
      check(res_valid, 16'h0);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      #1;
      check(line_ready, 16'h1);
      check(res_valid, 16'h0);
      @(posedge clk_i);
      t_fast();
      t_lcp();
      t_cross();
      t_false();
      t_fuse();
      t_fill();
      final_report();
   end
endmodule
